// file: rtl/rbr_host.sv
`timescale 1ns/100ps
`default_nettype none
module rbr_host #(
  parameter int StopWaitUs = rbr_pkg::STOP_WAIT_US
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device register pins
  output rbr_pkg::rbr_dev_pins_s devPins,
  input wire logic [7:0] devDataIn
);
  import rbr_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // new read pointer one page behind the next packet, wrapped to the last ring page below the ring start
  function automatic logic [7:0] releaseBoundary(input logic [7:0] npp, input logic [7:0] start,
                                                 input logic [7:0] stop);
    logic [7:0] b;
    b = npp - 8'h01;
    if (npp == 8'h00 || b < start) begin
      b = stop - 8'h01;
    end
    return b;
  endfunction

  function automatic logic isAccess(input rbr_state_e s);
    return !(s == ST_IDLE || s == ST_STOP_WAIT || s == ST_DRAIN);
  endfunction

  // register access carried out by each access state
  function automatic rbr_dev_req_s stepOp(input rbr_host_s h);
    rbr_dev_req_s r;
    r = '{wr: 1'b1, addr: DEV_CMD, data: 8'h00};
    case (h.st)
      ST_RD_CR: begin
        r.wr = 1'b0;
      end
      ST_WR_STOP: begin
        r.data = CMD_STOP;
      end
      ST_WR_RBC0: begin
        r.addr = DEV_COUNT_LOW;
      end
      ST_WR_RBC1: begin
        r.addr = DEV_COUNT_HIGH;
      end
      ST_RD_ISR: begin
        r.wr = 1'b0;
        r.addr = DEV_ISR;
      end
      ST_WR_LOOP: begin
        r.addr = DEV_TX_CFG;
        r.data = h.loop2 ? TX_CFG_LOOP2 : TX_CFG_LOOP1;
      end
      ST_WR_START: begin
        r.data = CMD_START;
      end
      ST_WR_CLROVW: begin
        r.addr = DEV_ISR;
        r.data = 8'(1 << ISR_OVW_BIT);
      end
      ST_WR_TCRN: begin
        r.addr = DEV_TX_CFG;
        r.data = TX_CFG_NORMAL;
      end
      ST_WR_RESEND: begin
        r.data = CMD_RESEND;
      end
      ST_INIT_START: begin
        r.addr = DEV_RING_START;
        r.data = h.ringStart;
      end
      ST_INIT_STOP: begin
        r.addr = DEV_RING_STOP;
        r.data = h.ringStop;
      end
      ST_INIT_BND, ST_REL_BND: begin
        r.addr = DEV_READ_PTR;
        r.data = h.boundary;
      end
      ST_INIT_CURR: begin
        r.addr = DEV_WRITE_PTR;
        r.data = h.ringStart;
      end
      default: begin
        r = '{wr: 1'b1, addr: DEV_CMD, data: 8'h00};
      end
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // state and sub-blocks
  // ---------------------------------------------------------------
  rbr_host_s q, d;
  logic devReqValid;
  rbr_dev_req_s devReq;
  logic devDone;
  logic [7:0] devRdata;
  logic timerStart;
  logic timerElapsed;
  logic apbAccess;
  logic apbWrite;
  logic unmapped;
  logic refused;

  assign devReqValid = isAccess(q.st) && !q.issued;
  assign devReq = stepOp(q);
  assign timerStart = (q.st == ST_WR_STOP) && devDone;

  rbr_dev_port u_port (
    .clock(clock),
    .rstn(rstn),
    .reqValid(devReqValid),
    .reqData(devReq),
    .reqDone(devDone),
    .readData(devRdata),
    .devPins(devPins),
    .devDataIn(devDataIn)
  );

  rbr_wait_timer #(.WaitUs(StopWaitUs)) u_timer (
    .clock(clock),
    .rstn(rstn),
    .start(timerStart),
    .elapsed(timerElapsed)
  );

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  // zero wait states; read data is latched in the setup cycle
  assign apbAccess = psel && penable;
  assign apbWrite = apbAccess && pwrite;
  assign pready = apbAccess;
  assign prdata = q.prdata;

  always_comb begin
    unmapped = 1'b1;
    refused = 1'b0;
    if (paddr == REG_CTRL) begin
      unmapped = 1'b0;
      refused = pwrite && (pwdata[CTRL_INIT] || pwdata[CTRL_RECOVER]) && (q.st != ST_IDLE);
    end else if (paddr == REG_RING) begin
      unmapped = 1'b0;
      refused = pwrite && (q.st != ST_IDLE);
    end else if (paddr == REG_NEXT) begin
      unmapped = 1'b0;
      refused = pwrite && !(q.st == ST_IDLE || q.st == ST_DRAIN);
    end else if (paddr == REG_STATUS) begin
      unmapped = 1'b0;
    end
  end

  assign pslverr = apbAccess && (unmapped || refused);

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.waitCnt = (q.st == ST_STOP_WAIT) ? q.waitCnt + 32'd1 : 32'd0;
    if (devReqValid) begin
      d.issued = 1'b1;
    end
    // read data for the coming access phase
    if (psel && !penable && !pwrite) begin
      if (paddr == REG_CTRL) begin
        d.prdata = {28'h0000000, q.loop2, 3'b000};
      end else if (paddr == REG_RING) begin
        d.prdata = {16'h0000, q.ringStop, q.ringStart};
      end else if (paddr == REG_NEXT) begin
        d.prdata = {24'h000000, q.nextPkt};
      end else if (paddr == REG_STATUS) begin
        d.prdata = {3'b000, q.st, q.nextPkt, q.boundary, 3'b000, q.done, q.zeroErr, q.resend,
                    q.st == ST_DRAIN, q.st != ST_IDLE};
      end else begin
        d.prdata = 32'h00000000;
      end
    end
    // software commands
    if (apbWrite && !unmapped && !refused) begin
      if (paddr == REG_CTRL) begin
        if (pwdata[CTRL_INIT] && q.st == ST_IDLE) begin
          d.done = 1'b0;
          if (q.ringStart == 8'h00) begin
            d.zeroErr = 1'b1;
          end else begin
            d.zeroErr = 1'b0;
            d.boundary = q.ringStart;
            d.nextPkt = q.ringStart;
            d.st = ST_INIT_START;
          end
        end else if (pwdata[CTRL_RECOVER] && q.st == ST_IDLE) begin
          d.done = 1'b0;
          d.loop2 = pwdata[CTRL_LOOP2];
          d.st = ST_RD_CR;
        end else if (pwdata[CTRL_FINISH] && q.st == ST_DRAIN) begin
          d.st = ST_WR_CLROVW;
        end
      end else if (paddr == REG_RING) begin
        d.ringStart = pwdata[7:0];
        d.ringStop = pwdata[15:8];
      end else if (paddr == REG_NEXT) begin
        // software moved one packet out with its own host addresses; advance the read pointer
        d.nextPkt = pwdata[7:0];
        d.boundary = releaseBoundary(pwdata[7:0], q.ringStart, q.ringStop);
        d.retDrain = (q.st == ST_DRAIN);
        d.st = ST_REL_BND;
      end
    end
    // device access finished: take its result and move on
    if (devDone) begin
      d.issued = 1'b0;
      case (q.st)
        ST_RD_CR: begin
          d.txpSeen = devRdata[CMD_TXP_BIT];
          d.st = ST_WR_STOP;
        end
        ST_WR_STOP: begin
          d.st = ST_STOP_WAIT;
        end
        ST_WR_RBC0: begin
          d.st = ST_WR_RBC1;
        end
        ST_WR_RBC1: begin
          if (q.txpSeen) begin
            d.st = ST_RD_ISR;
          end else begin
            d.resend = 1'b0;
            d.st = ST_WR_LOOP;
          end
        end
        ST_RD_ISR: begin
          d.resend = !(devRdata[ISR_PTX_BIT] || devRdata[ISR_TXE_BIT]);
          d.st = ST_WR_LOOP;
        end
        ST_WR_LOOP: begin
          d.st = ST_WR_START;
        end
        ST_WR_START: begin
          d.st = ST_DRAIN;
        end
        ST_WR_CLROVW: begin
          d.st = ST_WR_TCRN;
        end
        ST_WR_TCRN: begin
          d.st = q.resend ? ST_WR_RESEND : ST_IDLE;
          d.done = !q.resend;
        end
        ST_WR_RESEND: begin
          d.resend = 1'b0;
          d.done = 1'b1;
          d.st = ST_IDLE;
        end
        ST_INIT_START: begin
          d.st = ST_INIT_STOP;
        end
        ST_INIT_STOP: begin
          d.st = ST_INIT_BND;
        end
        ST_INIT_BND: begin
          d.st = ST_INIT_CURR;
        end
        ST_INIT_CURR: begin
          d.st = ST_IDLE;
        end
        ST_REL_BND: begin
          d.st = q.retDrain ? ST_DRAIN : ST_IDLE;
        end
        default: begin
          d.st = q.st;
        end
      endcase
    end
    // no reset-flag polling: only the fixed wait ends the stop phase
    if (q.st == ST_STOP_WAIT && timerElapsed) begin
      d.st = ST_WR_RBC0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      q <= '{st: ST_IDLE, issued: 1'b0, ringStart: 8'h00, ringStop: 8'h00, boundary: 8'h00,
             nextPkt: 8'h00, txpSeen: 1'b0, resend: 1'b0, loop2: 1'b0, zeroErr: 1'b0,
             done: 1'b0, retDrain: 1'b0, prdata: 32'h00000000, waitCnt: 32'd0};
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence stopIssued;
    devReqValid && q.st == ST_WR_STOP;
  endsequence

  sequence waitEntered;
    q.st == ST_STOP_WAIT;
  endsequence

  chk_stop_value: assert property (stopIssued |-> devReq.wr && devReq.data == CMD_STOP)
    else $error("stop command value wrong");
  chk_recover_order: assert property (stopIssued |-> ##[1:20] waitEntered)
    else $error("stop not followed by wait");
  chk_wait_length: assert property ((q.st == ST_STOP_WAIT && timerElapsed) |-> q.waitCnt == 32'(StopWaitUs * US_CYCLES))
    else $error("stop wait not the full time");
  chk_count_clear: assert property ((devReqValid && (q.st == ST_WR_RBC0 || q.st == ST_WR_RBC1)) |-> devReq.wr && devReq.data == 8'h00)
    else $error("remote count not cleared");
  chk_resend_decide: assert property ((devDone && q.st == ST_RD_ISR) |=> q.resend == !($past(devRdata[ISR_PTX_BIT]) || $past(devRdata[ISR_TXE_BIT])))
    else $error("resend decision wrong");
  chk_loop_mode: assert property ((devReqValid && q.st == ST_WR_LOOP) |-> devReq.data == (q.loop2 ? TX_CFG_LOOP2 : TX_CFG_LOOP1))
    else $error("loopback value wrong");
  chk_start_value: assert property ((devReqValid && q.st == ST_WR_START) |-> devReq.data == CMD_START ##[1:20] q.st == ST_DRAIN)
    else $error("start command wrong");
  chk_resend_value: assert property ((devReqValid && q.st == ST_WR_RESEND) |-> q.resend && devReq.data == CMD_RESEND)
    else $error("resend command wrong");
  chk_zero_start: assert property ((devReqValid && q.st == ST_INIT_START) |-> devReq.data != 8'h00)
    else $error("zero ring start written");
  chk_ptr_init: assert property ((devReqValid && (q.st == ST_INIT_BND || q.st == ST_INIT_CURR)) |-> devReq.data == q.ringStart)
    else $error("pointer not loaded with ring start");
endmodule
`default_nettype wire

// file: rtl/rbr_pkg.sv
package rbr_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STOP_WAIT_NS = 1600000;  // least wait after stop, 1.6 ms
  localparam int STOP_WAIT_US = (STOP_WAIT_NS + US_NS - 1) / US_NS;
  localparam int ACCESS_CYCLES = 2;       // strobe width of one device access

  // ---------------------------------------------------------------
  // device register map and values
  // ---------------------------------------------------------------
  localparam logic [3:0] DEV_CMD = 4'h0;
  localparam logic [3:0] DEV_RING_START = 4'h1;
  localparam logic [3:0] DEV_RING_STOP = 4'h2;
  localparam logic [3:0] DEV_READ_PTR = 4'h3;
  localparam logic [3:0] DEV_ISR = 4'h7;
  localparam logic [3:0] DEV_COUNT_LOW = 4'ha;
  localparam logic [3:0] DEV_COUNT_HIGH = 4'hb;
  localparam logic [3:0] DEV_TX_CFG = 4'hd;
  localparam logic [3:0] DEV_WRITE_PTR = 4'hf;
  localparam logic [7:0] CMD_STOP = 8'h21;
  localparam logic [7:0] CMD_START = 8'h22;
  localparam logic [7:0] CMD_RESEND = 8'h26;
  localparam int CMD_TXP_BIT = 2;
  localparam int ISR_PTX_BIT = 0;
  localparam int ISR_TXE_BIT = 3;
  localparam int ISR_OVW_BIT = 4;
  localparam logic [7:0] TX_CFG_NORMAL = 8'h00;
  localparam logic [7:0] TX_CFG_LOOP1 = 8'h02;
  localparam logic [7:0] TX_CFG_LOOP2 = 8'h04;

  // ---------------------------------------------------------------
  // own apb registers
  // ---------------------------------------------------------------
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_RING = 12'h004;
  localparam logic [11:0] REG_NEXT = 12'h008;
  localparam logic [11:0] REG_STATUS = 12'h00c;
  localparam int CTRL_INIT = 0;
  localparam int CTRL_RECOVER = 1;
  localparam int CTRL_FINISH = 2;
  localparam int CTRL_LOOP2 = 3;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h00, ST_RD_CR = 5'h01, ST_WR_STOP = 5'h03, ST_STOP_WAIT = 5'h02,
    ST_WR_RBC0 = 5'h06, ST_WR_RBC1 = 5'h07, ST_RD_ISR = 5'h05, ST_WR_LOOP = 5'h04,
    ST_WR_START = 5'h0c, ST_DRAIN = 5'h0d, ST_WR_CLROVW = 5'h0f, ST_WR_TCRN = 5'h0e,
    ST_WR_RESEND = 5'h0a, ST_INIT_START = 5'h18, ST_INIT_STOP = 5'h19,
    ST_INIT_BND = 5'h1b, ST_INIT_CURR = 5'h1a, ST_REL_BND = 5'h10
  } rbr_state_e;

  typedef struct packed {
    logic wr;
    logic [3:0] addr;
    logic [7:0] data;
  } rbr_dev_req_s;

  typedef struct packed {
    logic csN;
    logic rdN;
    logic wrN;
    logic [3:0] addr;
    logic [7:0] dout;
    logic doeN;
  } rbr_dev_pins_s;

  typedef struct packed {
    rbr_state_e st;
    logic issued;
    logic [7:0] ringStart;
    logic [7:0] ringStop;
    logic [7:0] boundary;
    logic [7:0] nextPkt;
    logic txpSeen;
    logic resend;
    logic loop2;
    logic zeroErr;
    logic done;
    logic retDrain;
    logic [31:0] prdata;
    logic [31:0] waitCnt;
  } rbr_host_s;
endpackage

// file: rtl/rbr_dev_port.sv
`timescale 1ns/100ps
`default_nettype none
module rbr_dev_port (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // access request
  input wire logic reqValid,
  input wire rbr_pkg::rbr_dev_req_s reqData,
  output logic reqDone,
  output logic [7:0] readData,
  // device register pins
  output rbr_pkg::rbr_dev_pins_s devPins,
  input wire logic [7:0] devDataIn
);
  import rbr_pkg::*;

  typedef struct packed {
    logic busy;
    logic [3:0] cnt;
    rbr_dev_pins_s pins;
    logic [7:0] rdata;
    logic done;
  } rbr_port_s;

  localparam rbr_dev_pins_s PINS_IDLE = '{csN: 1'b1, rdN: 1'b1, wrN: 1'b1, addr: 4'h0, dout: 8'h00, doeN: 1'b1};

  rbr_port_s q, d;

  // one strobe of ACCESS_CYCLES clocks, read data taken at its last edge
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (!q.busy) begin
      if (reqValid) begin
        d.busy = 1'b1;
        d.cnt = 4'(ACCESS_CYCLES - 1);
        d.pins = '{csN: 1'b0, rdN: reqData.wr, wrN: !reqData.wr, addr: reqData.addr,
                   dout: reqData.data, doeN: !reqData.wr};
      end
    end else if (q.cnt != 4'h0) begin
      d.cnt = q.cnt - 4'h1;
    end else begin
      d.busy = 1'b0;
      d.done = 1'b1;
      d.pins = PINS_IDLE;
      if (q.pins.wrN) begin
        d.rdata = devDataIn;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      q <= '{busy: 1'b0, cnt: 4'h0, pins: PINS_IDLE, rdata: 8'h00, done: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign reqDone = q.done;
  assign readData = q.rdata;
  assign devPins = q.pins;

  chk_access_done: assert property (@(posedge clock) disable iff (!rstn)
    (reqValid && !q.busy) |-> ##[1:16] q.done) else $error("device access never completed");
endmodule
`default_nettype wire

// file: rtl/rbr_wait_timer.sv
`timescale 1ns/100ps
`default_nettype none
module rbr_wait_timer #(
  parameter int WaitUs = rbr_pkg::STOP_WAIT_US
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // control
  input wire logic start,
  output logic elapsed
);
  import rbr_pkg::*;

  typedef struct packed {
    logic run;
    logic [7:0] div;
    logic [15:0] cnt;
    logic elapsed;
  } rbr_timer_s;

  rbr_timer_s q, d;

  // microsecond enable from a divider, then a microsecond count
  always_comb begin
    d = q;
    if (start) begin
      d = '{run: 1'b1, div: 8'h00, cnt: 16'h0000, elapsed: 1'b0};
    end else if (q.run) begin
      if (q.div == 8'(US_CYCLES - 1)) begin
        d.div = 8'h00;
        if (q.cnt == 16'(WaitUs - 1)) begin
          d.run = 1'b0;
          d.elapsed = 1'b1;
        end else begin
          d.cnt = q.cnt + 16'h0001;
        end
      end else begin
        d.div = q.div + 8'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      q <= '{run: 1'b0, div: 8'h00, cnt: 16'h0000, elapsed: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign elapsed = q.elapsed;
endmodule
`default_nettype wire

// file: tb/rbr_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
module rbr_dev_model (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // register pins from the host
  input wire rbr_pkg::rbr_dev_pins_s devPins,
  output logic [7:0] devDataIn,
  // bench preset of command and status
  input wire logic preset,
  input wire logic [7:0] cmdInit,
  input wire logic [7:0] isrInit
);
  import rbr_pkg::*;
  logic [7:0] regs [16];
  logic [7:0] lastQ;
  logic busQ;
  logic running;
  int cyc;
  logic [12:0] acc [$];
  int accTime [$];
  int strobeLen;
  int pinErr;
  // local dma keeps a page and a byte offset; the upper address half stays fixed outside
  logic [7:0] dmaPage;
  logic [7:0] dmaByte;
  logic [7:0] nextPage;
  int pktPages;
  // ---------------------------------------------------------------
  // register file, one log entry per strobe
  // ---------------------------------------------------------------
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 16; i++) regs[i] = 8'h00;
      busQ = 1'b0;
      running = 1'b0;
      lastQ = 8'h00;
      strobeLen = 0;
      dmaPage = 8'h00;
      dmaByte = 8'h00;
      pktPages = 0;
      acc.delete();
      accTime.delete();
    end else begin
      cyc++;
      lastQ = devDataIn;
      if (preset) begin
        regs[DEV_CMD] = cmdInit;
        regs[DEV_ISR] = isrInit;  // flags left by the device's own retries
      end
      // only the first cycle of a strobe counts, the strobe is two wide
      if (!devPins.csN && !busQ) begin
        acc.push_back({!devPins.wrN, devPins.addr, devPins.wrN ? regs[devPins.addr] : devPins.dout});
        accTime.push_back(cyc);
        if (!devPins.wrN && devPins.addr == DEV_ISR) begin
          regs[DEV_ISR] = regs[DEV_ISR] & ~devPins.dout;
        end else if (!devPins.wrN) begin
          regs[devPins.addr] = devPins.dout;
        end
        if (!devPins.wrN && devPins.addr == DEV_WRITE_PTR) begin
          dmaPage = devPins.dout;
          dmaByte = 8'h04;  // room left for the status header
        end
        if (!devPins.wrN && devPins.addr == DEV_CMD) running = !devPins.dout[0];  // halts at once
      end
      // strobe shape: exactly one of read or write low, data driven on writes only, fixed width
      if (!devPins.csN) begin
        strobeLen++;
        if (devPins.rdN == devPins.wrN || devPins.doeN != devPins.wrN) pinErr++;
      end else if (busQ) begin
        if (strobeLen != ACCESS_CYCLES) pinErr++;
        strobeLen = 0;
      end
      // local dma: 64-byte bursts from the fifo, four to a page
      if (running) begin
        if (dmaByte < 8'hc0) begin
          dmaByte = dmaByte + 8'h40;
        end else begin
          dmaByte = 8'h00;
          nextPage = dmaPage + 8'h01;  // contiguous link, never a skip
          if (nextPage == regs[DEV_RING_STOP]) nextPage = regs[DEV_RING_START];
          if (nextPage == regs[DEV_READ_PTR]) begin
            // ring full: drop this packet, stored ones stay intact
            regs[DEV_ISR][ISR_OVW_BIT] = 1'b1;
            dmaPage = regs[DEV_WRITE_PTR];
            dmaByte = 8'h04;
            pktPages = 0;
          end else if (pktPages == 5) begin
            // longest packet done: header at its first page, next on a fresh page
            regs[DEV_WRITE_PTR] = nextPage;
            dmaPage = nextPage;
            dmaByte = 8'h04;
            pktPages = 0;
          end else begin
            dmaPage = nextPage;
            pktPages++;
          end
        end
      end
      busQ = !devPins.csN;
    end
  end
  // released bus shows the inverse of its last value, never a stale copy
  always_comb devDataIn = (!devPins.csN && !devPins.rdN) ? regs[devPins.addr] : ~lastQ;
endmodule
`default_nettype wire

// file: tb/rbr_host_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module rbr_host_tb_top;
  import rbr_pkg::*;
  localparam int WaitUs = 3;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] interrupt_status_reg;
    logic loop2;
    logic resend;
    logic [7:0] nxt;
    logic [7:0] bnd;
  } rbr_row_s;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  rbr_dev_pins_s devPins;
  logic [7:0] devDataIn;
  logic preset = 1'b0;
  logic [7:0] cmdInit = '0;
  logic [7:0] isrInit = '0;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  int tAcc;
  int t0;
  logic [31:0] rd;
  logic err;
  rbr_row_s rows [4] = '{'{8'h00, 8'h10, 1'b0, 1'b0, 8'h50, 8'h4f}, '{8'h04, 8'h10, 1'b0, 1'b1, 8'h46, 8'h7f},
                         '{8'h04, 8'h11, 1'b1, 1'b0, 8'h7f, 8'h7e}, '{8'h04, 8'h18, 1'b0, 1'b0, 8'h47, 8'h46}};
  always #50 clock = ~clock;
  rbr_host #(.StopWaitUs(WaitUs)) i_rbr_host (.clock(clock), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .devPins(devPins), .devDataIn(devDataIn));
  rbr_dev_model i_rbr_dev_model (.clock(clock), .rstn(rstn), .devPins(devPins), .devDataIn(devDataIn),
    .preset(preset), .cmdInit(cmdInit), .isrInit(isrInit));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer; waits on pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // answer only moves at rising edges: its low-phase value is what the next edge takes
    do begin
      @(negedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    check("pready", 32'h1, {31'h0, pready});
    @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic waitStatus(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, '0);
      n++;
    end while (rd[b] !== v && n < 200);
    check("status bit", {31'h0, v}, {31'h0, rd[b]});
  endtask
  // next device access from the model log, bounded wait
  task automatic expectAcc(input logic [12:0] e);
    logic [12:0] g;
    repeat (100) if (i_rbr_dev_model.acc.size() == 0) @(posedge clock);
    g = 13'h1fff;
    if (i_rbr_dev_model.acc.size() > 0) begin
      g = i_rbr_dev_model.acc.pop_front();
      tAcc = i_rbr_dev_model.accTime.pop_front();
    end
    check("device access", {19'h0, e}, {19'h0, g});
  endtask
  // ---------------------------------------------------------------
  // timeout
  // ---------------------------------------------------------------
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    apb(1'b0, REG_STATUS, '0);
    check("status after reset", 32'h0, rd);
    check("pins idle", 32'h1, {31'h0, devPins.csN});
    apb(1'b0, 12'h010, '0);
    check("unmapped error", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rd);
    $display("test reset done");
    apb(1'b1, REG_RING, 32'h8000);
    apb(1'b1, REG_CTRL, 32'h1);
    waitStatus(3, 1'b1);
    check("no write on zero start", 32'h0, i_rbr_dev_model.acc.size());
    apb(1'b1, REG_RING, 32'h8046);
    apb(1'b1, REG_CTRL, 32'h1);
    expectAcc({1'b1, DEV_RING_START, 8'h46});
    expectAcc({1'b1, DEV_RING_STOP, 8'h80});
    expectAcc({1'b1, DEV_READ_PTR, 8'h46});
    expectAcc({1'b1, DEV_WRITE_PTR, 8'h46});
    waitStatus(0, 1'b0);
    apb(1'b0, REG_RING, '0);
    check("ring read", 32'h8046, rd);
    $display("test init done");
    foreach (rows[i]) begin
      cmdInit <= rows[i].cmd;
      isrInit <= rows[i].interrupt_status_reg;
      preset <= 1'b1;
      @(posedge clock);
      preset <= 1'b0;
      apb(1'b1, REG_CTRL, {28'h0, rows[i].loop2, 3'b010});
      expectAcc({1'b0, DEV_CMD, rows[i].cmd});
      expectAcc({1'b1, DEV_CMD, CMD_STOP});
      t0 = tAcc;
      expectAcc({1'b1, DEV_COUNT_LOW, 8'h00});
      check("stop wait", 32'h1, {31'h0, 1'((tAcc - t0) >= WaitUs * US_CYCLES)});
      expectAcc({1'b1, DEV_COUNT_HIGH, 8'h00});
      if (rows[i].cmd[CMD_TXP_BIT]) expectAcc({1'b0, DEV_ISR, rows[i].interrupt_status_reg});
      expectAcc({1'b1, DEV_TX_CFG, rows[i].loop2 ? TX_CFG_LOOP2 : TX_CFG_LOOP1});
      expectAcc({1'b1, DEV_CMD, CMD_START});
      waitStatus(1, 1'b1);
      check("resend flag", {31'h0, rows[i].resend}, {31'h0, rd[2]});
      check("device running", 32'h1, {31'h0, i_rbr_dev_model.running});
      apb(1'b1, REG_RING, 32'h8046);
      check("ring refused while busy", 32'h1, {31'h0, err});
      apb(1'b1, REG_NEXT, {24'h0, rows[i].nxt});
      check("next accepted", 32'h0, {31'h0, err});
      expectAcc({1'b1, DEV_READ_PTR, rows[i].bnd});
      apb(1'b0, REG_STATUS, '0);
      check("read pointer", {24'h0, rows[i].bnd}, {24'h0, rd[15:8]});
      check("next page", {24'h0, rows[i].nxt}, {24'h0, rd[23:16]});
      apb(1'b1, REG_CTRL, 32'h4);
      expectAcc({1'b1, DEV_ISR, 8'h10});
      expectAcc({1'b1, DEV_TX_CFG, TX_CFG_NORMAL});
      if (rows[i].resend) expectAcc({1'b1, DEV_CMD, CMD_RESEND});
      waitStatus(4, 1'b1);
      check("no extra access", 32'h0, i_rbr_dev_model.acc.size());
      apb(1'b0, REG_CTRL, '0);
      check("loop mode", {28'h0, rows[i].loop2, 3'b000}, rd);
      $display("test recover row %0d done", i);
    end
    // reset in the middle of a recovery, during the stop wait
    apb(1'b1, REG_CTRL, 32'h2);
    expectAcc({1'b0, DEV_CMD, CMD_START});
    expectAcc({1'b1, DEV_CMD, CMD_STOP});
    repeat (5) @(posedge clock);
    rstn <= 1'b0;
    @(posedge clock);
    rstn <= 1'b1;
    apb(1'b0, REG_STATUS, '0);
    check("status after mid reset", 32'h0, rd);
    check("pins idle after mid reset", 32'h1, {31'h0, devPins.csN});
    apb(1'b1, REG_RING, 32'h8046);
    apb(1'b1, REG_CTRL, 32'h1);
    expectAcc({1'b1, DEV_RING_START, 8'h46});
    check("pin protocol", 32'h0, i_rbr_dev_model.pinErr);
    $display("test mid reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
